/* hdl/imu_out_params.svh */
// Constants of the inertial output data registers: offsets, limits, scales.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef IMU_OUT_PARAMS_SVH
`define IMU_OUT_PARAMS_SVH

// Byte addresses of the output words, low byte of each pair
`define OFS_X_RATE_LOW    7'h04
`define OFS_X_RATE_HIGH   7'h06
`define OFS_Y_RATE_LOW    7'h08
`define OFS_Y_RATE_HIGH   7'h0a
`define OFS_Z_RATE_LOW    7'h0c
`define OFS_Z_RATE_HIGH   7'h0e
`define OFS_X_ACCEL_LOW   7'h10
`define OFS_X_ACCEL_HIGH  7'h12

// Reset value of every output word and of the read response
`define OUT_WORD_RESET    16'h0000

// Full-scale high words
`define RATE_FS_POS       16'h4e20
`define RATE_FS_NEG       16'hb1e0
`define ACCEL_FS_POS      16'h7d00
`define ACCEL_FS_NEG      16'h8300

// Scale factor per high-word count, micro-deg/s and micro-g
`define RATE_SCALE_125_UDPS   6250
`define RATE_SCALE_500_UDPS   25000
`define RATE_SCALE_2000_UDPS  100000
`define ACCEL_SCALE_UG        250

// Serial frame layout
`define FRAME_BITS        5'd16
`define FRAME_READ_BIT    15
`define FRAME_ADDR_MSB    14
`define FRAME_ADDR_LSB    8

`endif

/* hdl/imu_out_pkg.sv */
// Types shared by the inertial output data register block.
// Assumes nothing beyond a SystemVerilog compiler.
package imu_out_pkg;

   typedef logic [15:0] word_t;
   typedef logic [31:0] wide_t;
   typedef logic [6:0]  addr_t;

   // Gyroscope range model, fixed by the strap pins
   typedef enum logic [2:0] {
      MODEL_125  = 3'b001,
      MODEL_500  = 3'b010,
      MODEL_2000 = 3'b100
   } range_model_e;

   // Serial port frame state
   typedef enum logic [1:0] {
      LINK_IDLE  = 2'b01,
      LINK_FRAME = 2'b10
   } link_state_e;

endpackage

/* hdl/sat_shift.sv */
// Arithmetic right shift with two's complement clamp to a full-scale pair.
// Assumes a 32-bit signed input in finer units than the output count.
`timescale 1ns/1ps
`default_nettype none

module sat_shift #(
   parameter logic [15:0] LIMIT_POS = 16'h7fff,
   parameter logic [15:0] LIMIT_NEG = 16'h8000
) (
   input  wire  logic [31:0] data_i,
   input  wire  logic [2:0]  shift_i,
   output logic        [31:0] data_o
);

   logic signed [31:0] shifted;
   logic signed [31:0] lim_pos;
   logic signed [31:0] lim_neg;

   // Clamp keeps the low word zero at full scale, so the pair stays exact
   always_comb begin
      shifted = $signed(data_i) >>> shift_i;
      lim_pos = $signed({LIMIT_POS, 16'h0000});
      lim_neg = $signed({LIMIT_NEG, 16'h0000});
      if (shifted > lim_pos) begin
         data_o = lim_pos;
      end else if (shifted < lim_neg) begin
         data_o = lim_neg;
      end else begin
         data_o = shifted;
      end
   end

endmodule

`default_nettype wire

/* hdl/spi_frame_port.sv */
// Serial port of the output registers: 16-bit frames, clock idles high.
// Assumes pin inputs asynchronous to clk_i and sclk at most clk_i / 8.
`timescale 1ns/1ps
`default_nettype none
`include "imu_out_params.svh"

module spi_frame_port (
   input  wire  logic               clk_i,
   input  wire  logic               resetn_i,
   input  wire  logic               sclk_i,
   input  wire  logic               cs_n_i,
   input  wire  logic               mosi_i,
   input  wire  imu_out_pkg::word_t tx_word_i,
   output logic                     miso_o,
   output logic                     miso_oe_o,
   output logic                     cmd_valid_o,
   output logic                     cmd_read_o,
   output imu_out_pkg::addr_t       cmd_addr_o
);
   import imu_out_pkg::*;

   logic [2:0]  sclk_sync_reg;
   logic [2:0]  cs_sync_reg;
   logic [1:0]  mosi_sync_reg;
   link_state_e state_reg;
   logic [4:0]  bit_cnt_reg;
   word_t       rx_shift_reg;
   word_t       tx_shift_reg;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_fall;
   logic        cs_rise;

   // Pin synchronisers; stage 0 feeds only stage 1, edges use stages 1 and 2
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sclk_sync_reg <= 3'h7;
         cs_sync_reg   <= 3'h7;
         mosi_sync_reg <= 2'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
         cs_sync_reg   <= {cs_sync_reg[1:0], cs_n_i};
         mosi_sync_reg <= {mosi_sync_reg[0], mosi_i};
      end
   end

   assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
   assign cs_fall   = ~cs_sync_reg[1] & cs_sync_reg[2];
   assign cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];

   // Frame engine: sample on rising sclk, shift out on falling sclk
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg    <= LINK_IDLE;
         bit_cnt_reg  <= 5'h00;
         rx_shift_reg <= `OUT_WORD_RESET;
         tx_shift_reg <= `OUT_WORD_RESET;
         miso_o       <= 1'b0;
         miso_oe_o    <= 1'b0;
         cmd_valid_o  <= 1'b0;
         cmd_read_o   <= 1'b0;
         cmd_addr_o   <= 7'h00;
      end else begin
         cmd_valid_o <= 1'b0;
         unique case (state_reg)
            LINK_IDLE: begin
               if (cs_fall) begin
                  state_reg    <= LINK_FRAME;
                  bit_cnt_reg  <= 5'h00;
                  tx_shift_reg <= tx_word_i;
                  miso_o       <= tx_word_i[15];
                  miso_oe_o    <= 1'b1;
               end
            end
            LINK_FRAME: begin
               if (cs_rise) begin
                  state_reg <= LINK_IDLE;
                  miso_oe_o <= 1'b0;
                  // A frame of any other length is dropped whole
                  if (bit_cnt_reg == `FRAME_BITS) begin
                     cmd_valid_o <= 1'b1;
                     cmd_read_o  <= ~rx_shift_reg[`FRAME_READ_BIT];
                     cmd_addr_o  <= rx_shift_reg[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];
                  end
               end else begin
                  if (sclk_rise) begin
                     rx_shift_reg <= {rx_shift_reg[14:0], mosi_sync_reg[1]};
                     if (bit_cnt_reg != 5'h1f) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                     end
                  end
                  if (sclk_fall) begin
                     miso_o       <= tx_shift_reg[15];
                     tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
                  end
               end
            end
         endcase
      end
   end

endmodule

`default_nettype wire

/* hdl/imu_output_regs.sv */
// Output data registers: three rate axes and the X acceleration axis.
// Assumes raw samples arrive on clk_i with a one-cycle valid strobe and
// that a serial host reads the words over the four-wire frame port.
`timescale 1ns/1ps
`default_nettype none
`include "imu_out_params.svh"

// Contract
// - Rate high word two's complement, zero is zero
// - Scale per count follows the range model
// - Rate full scale clamps to plus/minus 20000
// - Rate low word extends to 32-bit value
// - X rate low 0x04, high 0x06, read-only
// - Y rate low 0x08, high 0x0A, read-only
// - Z rate low 0x0C, high 0x0E, read-only
// - Accel high word 0.25 mg, clamps 32000
// - Accel 32-bit pair full scale 0x7D000000
// - X accel high word at 0x12, read-only
module imu_output_regs (
   input  wire  logic                     clk_i,
   input  wire  logic                     resetn_i,
   input  wire  logic [1:0]               range_model_i,
   input  wire  logic                     sample_valid_i,
   input  wire  imu_out_pkg::wide_t       rate_x_raw_i,
   input  wire  imu_out_pkg::wide_t       rate_y_raw_i,
   input  wire  imu_out_pkg::wide_t       rate_z_raw_i,
   input  wire  imu_out_pkg::wide_t       accel_x_raw_i,
   input  wire  logic                     sclk_i,
   input  wire  logic                     cs_n_i,
   input  wire  logic                     mosi_i,
   output logic                           miso_o,
   output logic                           miso_oe_o,
   output imu_out_pkg::range_model_e      range_model_o
);
   import imu_out_pkg::*;

   localparam int CHANNELS = 4;
   localparam int ACCEL_CH = 3;

   // Shift from the finest scale to each model's scale, derived from scales
   localparam logic [2:0] SHIFT_125  = 3'h0;
   localparam logic [2:0] SHIFT_500  =
      3'($clog2(`RATE_SCALE_500_UDPS / `RATE_SCALE_125_UDPS));
   localparam logic [2:0] SHIFT_2000 =
      3'($clog2(`RATE_SCALE_2000_UDPS / `RATE_SCALE_125_UDPS));

   logic [1:0]             strap_meta_reg;
   logic [1:0]             strap_sync_reg;
   logic                   strap_taken_reg;
   range_model_e           model_reg;
   logic [2:0]             rate_shift;
   wide_t [CHANNELS-1:0]   raw_arr;
   wide_t [CHANNELS-1:0]   scaled_arr;
   wide_t [CHANNELS-1:0]   chan_reg;
   word_t                  resp_reg;
   logic                   cmd_valid;
   logic                   cmd_read;
   addr_t                  cmd_addr;

   // Strap pins to range model; both 1x codes fall to the widest range
   function automatic range_model_e model_decode(input logic [1:0] strap);
      range_model_e m;
      m = MODEL_2000;
      if (strap == 2'b00) begin
         m = MODEL_125;
      end else if (strap == 2'b01) begin
         m = MODEL_500;
      end
      return m;
   endfunction

   // Range model to right shift of the raw rate
   function automatic logic [2:0] model_shift(input range_model_e m);
      logic [2:0] s;
      s = SHIFT_125;
      unique case (m)
         MODEL_125:  s = SHIFT_125;
         MODEL_500:  s = SHIFT_500;
         MODEL_2000: s = SHIFT_2000;
         default:    s = SHIFT_125;
      endcase
      return s;
   endfunction

   // Read decode; odd addresses give the word of their pair
   function automatic word_t read_word(input addr_t a,
                                       input wide_t [CHANNELS-1:0] ch);
      word_t w;
      w = `OUT_WORD_RESET;
      case ({a[6:1], 1'b0})
         `OFS_X_RATE_LOW:   w = ch[0][15:0];
         `OFS_X_RATE_HIGH:  w = ch[0][31:16];
         `OFS_Y_RATE_LOW:   w = ch[1][15:0];
         `OFS_Y_RATE_HIGH:  w = ch[1][31:16];
         `OFS_Z_RATE_LOW:   w = ch[2][15:0];
         `OFS_Z_RATE_HIGH:  w = ch[2][31:16];
         `OFS_X_ACCEL_LOW:  w = ch[ACCEL_CH][15:0];
         `OFS_X_ACCEL_HIGH: w = ch[ACCEL_CH][31:16];
         default:           w = `OUT_WORD_RESET;
      endcase
      return w;
   endfunction

   // Strap synchroniser, free of logic between its two stages
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         strap_meta_reg <= 2'h0;
         strap_sync_reg <= 2'h0;
      end else begin
         strap_meta_reg <= range_model_i;
         strap_sync_reg <= strap_meta_reg;
      end
   end

   // Model caught once, on the third edge after release; any earlier and the
   // second stage still holds its reset value, which always reads as 125
   logic [1:0] strap_wait_reg;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         strap_wait_reg  <= 2'h0;
         strap_taken_reg <= 1'b0;
         model_reg       <= MODEL_125;
      end else begin
         strap_wait_reg <= {strap_wait_reg[0], 1'b1};
         if (strap_wait_reg[1] && !strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            model_reg       <= model_decode(strap_sync_reg);
         end
      end
   end

   assign range_model_o = model_reg;
   assign rate_shift    = model_shift(model_reg);
   assign raw_arr       = {accel_x_raw_i, rate_z_raw_i, rate_y_raw_i, rate_x_raw_i};

   // Scaling and clamping per channel; acceleration needs no shift
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_chan
         if (g < ACCEL_CH) begin : g_rate
            sat_shift #(
               .LIMIT_POS (`RATE_FS_POS),
               .LIMIT_NEG (`RATE_FS_NEG)
            ) u_sat (
               .data_i  (raw_arr[g]),
               .shift_i (rate_shift),
               .data_o  (scaled_arr[g])
            );
         end else begin : g_accel
            sat_shift #(
               .LIMIT_POS (`ACCEL_FS_POS),
               .LIMIT_NEG (`ACCEL_FS_NEG)
            ) u_sat (
               .data_i  (raw_arr[g]),
               .shift_i (3'h0),
               .data_o  (scaled_arr[g])
            );
         end
      end
   endgenerate

   // Whole 32-bit pairs load together; a read never sees half an update
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         chan_reg <= '0;
      end else if (sample_valid_i) begin
         chan_reg <= scaled_arr;
      end
   end

   // Serial frame port; answer of a read goes out in the following frame
   spi_frame_port u_port (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .sclk_i      (sclk_i),
      .cs_n_i      (cs_n_i),
      .mosi_i      (mosi_i),
      .tx_word_i   (resp_reg),
      .miso_o      (miso_o),
      .miso_oe_o   (miso_oe_o),
      .cmd_valid_o (cmd_valid),
      .cmd_read_o  (cmd_read),
      .cmd_addr_o  (cmd_addr)
   );

   // Read response; writes are ignored since every word is read-only
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         resp_reg <= `OUT_WORD_RESET;
      end else if (cmd_valid && cmd_read) begin
         resp_reg <= read_word(cmd_addr, chan_reg);
      end
   end

   // Register-side checks only; pin timing is left to the host model
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   rate_x_range_a: assert property (
      $signed(chan_reg[0][31:16]) <= $signed(`RATE_FS_POS) &&
      $signed(chan_reg[0][31:16]) >= $signed(`RATE_FS_NEG))
      else $error("x rate high word beyond full scale");

   // Only the positive end pins the low word; a high word at the negative
   // limit still carries legal fractions above that limit
   rate_fs_low_a: assert property (
      chan_reg[0][31:16] == `RATE_FS_POS |-> chan_reg[0][15:0] == 16'h0000)
      else $error("x rate low word not zero at full scale");

   accel_clamp_a: assert property (
      sample_valid_i && !accel_x_raw_i[31] &&
      $signed(accel_x_raw_i) > $signed({`ACCEL_FS_POS, 16'h0000})
      |=> chan_reg[ACCEL_CH] == {`ACCEL_FS_POS, 16'h0000})
      else $error("accel not clamped to positive full scale");

   zero_rate_a: assert property (
      sample_valid_i && rate_z_raw_i == 32'h0000_0000
      |=> chan_reg[2] == 32'h0000_0000)
      else $error("zero rate does not read as zero");

   model_scale_a: assert property (
      sample_valid_i && model_reg == MODEL_2000 && rate_x_raw_i[31:24] == 8'h00
      |=> chan_reg[0] == ($past(rate_x_raw_i) >> 4))
      else $error("wide range model not scaled by sixteen");

   pair_hold_a: assert property (
      !sample_valid_i |=> $stable(chan_reg))
      else $error("output pair changed without a sample update");

   read_x_high_a: assert property (
      cmd_valid && cmd_read && cmd_addr == `OFS_X_RATE_HIGH
      |=> resp_reg == $past(chan_reg[0][31:16]))
      else $error("x rate high word read wrong");

   read_accel_low_a: assert property (
      cmd_valid && cmd_read && cmd_addr == `OFS_X_ACCEL_LOW
      |=> resp_reg == $past(chan_reg[ACCEL_CH][15:0]))
      else $error("x accel low word read wrong");

   read_accel_high_a: assert property (
      cmd_valid && cmd_read && cmd_addr == `OFS_X_ACCEL_HIGH
      |=> resp_reg == $past(chan_reg[ACCEL_CH][31:16]))
      else $error("x accel high word read wrong");

   read_z_low_a: assert property (
      cmd_valid && cmd_read && cmd_addr == `OFS_Z_RATE_LOW
      ##1 !(cmd_valid && cmd_read)
      |=> resp_reg == $past(chan_reg[2][15:0], 2))
      else $error("z rate low word read wrong or not held");

   read_y_high_a: assert property (
      cmd_valid && cmd_read && cmd_addr == `OFS_Y_RATE_HIGH
      |=> resp_reg == $past(chan_reg[1][31:16]))
      else $error("y rate high word read wrong");

   // A sample may land during a write; only then may the words move
   write_ignored_a: assert property (
      cmd_valid && !cmd_read
      |=> $stable(resp_reg) && ($past(sample_valid_i) || $stable(chan_reg)))
      else $error("write frame changed read-only state");

   model_hold_a: assert property (
      strap_taken_reg |=> $stable(model_reg))
      else $error("range model moved after capture");

   rate_neg_clamp_a: assert property (
      sample_valid_i && model_reg == MODEL_125 &&
      $signed(rate_y_raw_i) < $signed({`RATE_FS_NEG, 16'h0000})
      |=> chan_reg[1] == {`RATE_FS_NEG, 16'h0000})
      else $error("y rate not clamped to negative full scale");

   accel_neg_clamp_a: assert property (
      sample_valid_i &&
      $signed(accel_x_raw_i) < $signed({`ACCEL_FS_NEG, 16'h0000})
      |=> chan_reg[ACCEL_CH] == {`ACCEL_FS_NEG, 16'h0000})
      else $error("accel not clamped to negative full scale");

   // Response path: the word lands one cycle after the command pulse and
   // is taken from the words as they stood at that pulse
   read_x_low_a: assert property (
      cmd_valid && cmd_read && cmd_addr == `OFS_X_RATE_LOW
      |=> resp_reg == $past(chan_reg[0][15:0]))
      else $error("x rate low word read wrong");

   read_y_low_a: assert property (
      cmd_valid && cmd_read && cmd_addr == `OFS_Y_RATE_LOW
      |=> resp_reg == $past(chan_reg[1][15:0]))
      else $error("y rate low word read wrong");

   read_z_high_a: assert property (
      cmd_valid && cmd_read && cmd_addr == `OFS_Z_RATE_HIGH
      |=> resp_reg == $past(chan_reg[2][31:16]))
      else $error("z rate high word read wrong");

   unmapped_read_a: assert property (
      cmd_valid && cmd_read && cmd_addr >= 7'h14
      |=> resp_reg == `OUT_WORD_RESET)
      else $error("word past the map did not read zero");

endmodule

`default_nettype wire

/* testbench/serial_host_model.sv */
// Serial host model: sends read and write frames to the output register port.
// Assumes the bench clock at 40 MHz and a port answering a read in the next frame.
`timescale 1ns/1ps
`default_nettype none

module serial_host_model #(
   parameter int HALF = 8,
   parameter int GAP  = 10
) (
   input  wire logic clk_i,
   input  wire logic miso_i,
   input  wire logic miso_oe_i,
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o
);
   import imu_out_pkg::*;

   // Idle bus: clock parked high, device deselected
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // One frame, MSB first; a bit seen while miso is undriven reads as unknown
   task automatic xfer(input word_t cmd, input int nbits, output word_t resp);
      int i;
      resp = '0;
      @(negedge clk_i);
      cs_n_o <= 1'b0;
      repeat (HALF) @(negedge clk_i);
      for (i = 0; i < nbits; i++) begin
         sclk_o <= 1'b0;
         mosi_o <= cmd[15 - i];
         repeat (HALF) @(negedge clk_i);
         sclk_o <= 1'b1;
         resp = {resp[14:0], miso_oe_i ? miso_i : 1'bx};
         repeat (HALF) @(negedge clk_i);
      end
      cs_n_o <= 1'b1;
      // Released line shows the inverse, so a stale copy is never trusted
      mosi_o <= ~mosi_o;
      // Long gap so the response is latched before the next frame
      repeat (GAP) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

/* testbench/test_inertial_output_data_registers.sv */
// Self-checking bench of the output data registers, read over the serial port.
// Assumes the design package and parameter header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "imu_out_params.svh"

module test_inertial_output_data_registers;
   import imu_out_pkg::*;

   logic         clk, resetn, sample_valid, sclk, cs_n, mosi, miso, miso_oe;
   logic [1:0]   strap;
   wide_t        rx, ry, rz, ax, xe, ye, ze, ae;
   range_model_e model;
   int           err_total, checks, k;
   word_t        pend_exp;
   string        pend_name;
   int           stab [4] = '{0, 2, 4, 4};
   range_model_e mtab [4] = '{MODEL_125, MODEL_500, MODEL_2000, MODEL_2000};
   wide_t        atab [4] = '{32'h7fffffff, 32'h80000000, 32'hffffffff, 32'h12345678};

   // 40 MHz clock
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   imu_output_regs i_dut (
      .clk_i          (clk),
      .resetn_i       (resetn),
      .range_model_i  (strap),
      .sample_valid_i (sample_valid),
      .rate_x_raw_i   (rx),
      .rate_y_raw_i   (ry),
      .rate_z_raw_i   (rz),
      .accel_x_raw_i  (ax),
      .sclk_i         (sclk),
      .cs_n_i         (cs_n),
      .mosi_i         (mosi),
      .miso_o         (miso),
      .miso_oe_o      (miso_oe),
      .range_model_o  (model)
   );

   serial_host_model i_host (
      .clk_i     (clk),
      .miso_i    (miso),
      .miso_oe_i (miso_oe),
      .sclk_o    (sclk),
      .cs_n_o    (cs_n),
      .mosi_o    (mosi)
   );

   // Verdict and end of run
   task automatic close_out();
      if (err_total == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Compare tasks, one per kind of result
   task automatic cmp_word(input string name, input word_t exp, input word_t got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cmp_model(input string name, input range_model_e exp, input range_model_e got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic cmp_bit(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Clamp a 32-bit value to a full-scale pair of high words
   function automatic wide_t clamp(input wide_t v, input word_t pos, input word_t neg);
      if ($signed(v) > $signed({pos, 16'h0000})) return {pos, 16'h0000};
      if ($signed(v) < $signed({neg, 16'h0000})) return {neg, 16'h0000};
      return v;
   endfunction

   // Raw rate is in the finest model unit; coarser models drop low bits
   function automatic wide_t rate_exp(input wide_t raw, input int sh);
      return clamp($signed(raw) >>> sh, `RATE_FS_POS, `RATE_FS_NEG);
   endfunction

   // Strap pins are only caught after a reset, so each model needs one
   task automatic do_reset(input logic [1:0] code);
      @(negedge clk);
      resetn <= 1'b0;
      strap <= code;
      repeat (12) @(negedge clk);
      resetn <= 1'b1;
      repeat (8) @(negedge clk);
      pend_exp = `OUT_WORD_RESET;
      pend_name = "response after reset";
   endtask

   // One sample strobe; last high ends a back-to-back run
   task automatic load(input wide_t x, input wide_t y, input wide_t z, input wide_t a,
                       input logic last);
      rx <= x;
      ry <= y;
      rz <= z;
      ax <= a;
      sample_valid <= 1'b1;
      @(negedge clk);
      if (last) sample_valid <= 1'b0;
   endtask

   // Read frame: its response belongs to the read before it
   task automatic rd(input addr_t a, input word_t e, input string name);
      word_t r;
      i_host.xfer({1'b0, a, 8'h5a}, 16, r);
      cmp_word(pend_name, pend_exp, r);
      cmp_bit("miso enable between frames", 1'b0, miso_oe);
      pend_exp = e;
      pend_name = name;
   endtask

   // Write frame: ignored, so the held response must survive it
   task automatic wr(input addr_t a);
      word_t r;
      i_host.xfer({1'b1, a, 8'hff}, 16, r);
      cmp_word(pend_name, pend_exp, r);
   endtask

   // Watchdog against a hung run
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      close_out();
   end

   // Main sequence
   initial begin
      word_t r;
      err_total = 0;
      checks = 0;
      resetn = 1'b0;
      strap = 2'b00;
      sample_valid = 1'b0;
      rx = '0;
      ry = '0;
      rz = '0;
      ax = '0;
      for (k = 0; k < 4; k++) begin
         do_reset(k[1:0]);
         cmp_model("range model", mtab[k], model);
         rd(`OFS_X_RATE_HIGH, `OUT_WORD_RESET, "x rate high before data");
         @(negedge clk);
         load(32'h7fffffff, 32'h80000000, 32'hfffe8001, atab[k], 1'b1);
         xe = rate_exp(32'h7fffffff, stab[k]);
         ye = rate_exp(32'h80000000, stab[k]);
         ze = rate_exp(32'hfffe8001, stab[k]);
         ae = clamp(atab[k], `ACCEL_FS_POS, `ACCEL_FS_NEG);
         rd(`OFS_X_RATE_HIGH, xe[31:16], "x rate high");
         rd(`OFS_X_RATE_LOW, xe[15:0], "x rate low");
         rd(`OFS_Y_RATE_HIGH, ye[31:16], "y rate high");
         rd(`OFS_Y_RATE_LOW, ye[15:0], "y rate low");
         rd(`OFS_Z_RATE_HIGH, ze[31:16], "z rate high");
         rd(`OFS_Z_RATE_LOW, ze[15:0], "z rate low");
         rd(`OFS_X_ACCEL_HIGH, ae[31:16], "x accel high");
         rd(`OFS_X_ACCEL_LOW, ae[15:0], "x accel low");
         // Collects the accel low answer before the next reset clears it
         rd(7'h00, 16'h0000, "unmapped before reset");
      end
      // Back-to-back samples: both halves must come from the second
      @(negedge clk);
      // First sample stays unclamped under the wide model, so its scaling shows
      load(32'h00234567, 32'h0, 32'h0, 32'h0, 1'b0);
      load(32'hfedcba98, 32'h0, 32'h0, 32'h0, 1'b1);
      xe = rate_exp(32'hfedcba98, 4);
      rd(`OFS_X_RATE_LOW, xe[15:0], "x rate low second sample");
      rd(7'h07, xe[31:16], "x rate high odd byte");
      rd(7'h14, 16'h0000, "unmapped word");
      rd(7'h02, 16'h0000, "word below map");
      wr(`OFS_X_RATE_HIGH);
      rd(`OFS_X_RATE_HIGH, xe[31:16], "x rate high after write");
      // Short frame must be dropped, leaving the pending response in place
      i_host.xfer({1'b0, `OFS_X_RATE_LOW, 8'h00}, 15, r);
      rd(7'h00, 16'h0000, "unmapped word zero");
      rd(7'h00, 16'h0000, "flush");
      close_out();
   end
endmodule
`default_nettype wire
